/* File: tic_defines.svh */
// Register offsets, control word fields and reset values of the counter block
`ifndef TIC_DEFINES_SVH
`define TIC_DEFINES_SVH

// Byte offsets of the host registers
`define TIC_OFS_CTR0      8'h18
`define TIC_OFS_CTR1      8'h19
`define TIC_OFS_CTR2      8'h1a
`define TIC_OFS_CTRL      8'h1b

// Control word fields
`define TIC_SEL_HI        7
`define TIC_SEL_LO        6
`define TIC_ACC_HI        5
`define TIC_ACC_LO        4
`define TIC_MODE_HI       3
`define TIC_MODE_LO       1
`define TIC_BCD_BIT       0
`define TIC_SEL_READBACK  2'h3

// Read-back command fields
`define TIC_RB_COUNT_N    5
`define TIC_RB_STATUS_N   4
`define TIC_RB_PICK_LO    1

// Byte access kinds
`define TIC_ACC_LATCH     2'h0
`define TIC_ACC_LSB       2'h1
`define TIC_ACC_MSB       2'h2
`define TIC_ACC_BOTH      2'h3

// Read data reset value, and value of reads that hit no counter
`define TIC_RDATA_RST     8'h00
`define TIC_UNMAPPED_RD   8'h00

`endif

/* File: tic_pkg.sv */
// Types shared by the triple interval counter
package tic_pkg;

   // One host access to the byte-wide register port
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } tic_req_t;

   // Complete state of one counter channel
   typedef struct packed {
      logic [15:0] count;
      logic [15:0] init;
      logic [15:0] hold;
      logic [7:0]  status;
      logic [1:0]  access;
      logic [2:0]  mode;
      logic        bcd;
      logic        out;
      logic        null_cnt;
      logic        loaded;
      logic        armed;
      logic        load_pend;
      logic        trig;
      logic        wr_hi;
      logic        rd_hi;
      logic        cnt_latched;
      logic        sta_latched;
   } tic_ctr_t;

endpackage

/* File: tic_interval_counter.sv */
// Three 16-bit programmable down counters behind a byte-wide host port
`timescale 1ns/1ps
`include "tic_defines.svh"

module tic_interval_counter
#(
   parameter int NUM_CTR = 3
)
(
   input  wire logic              ref_clk,
   input  wire logic              reset_n,
   input  wire tic_pkg::tic_req_t host_req,
   output logic [7:0]             host_rdata,
   input  wire logic [NUM_CTR-1:0] count_clk,
   input  wire logic [NUM_CTR-1:0] count_gate,
   output logic [NUM_CTR-1:0]     count_out
);

   // One decrement, binary or four decimal digits with borrow
   function automatic logic [15:0] dec1(input logic [15:0] v,
                                        input logic        bcd);
      logic [15:0] r;
      logic        borrow;
      r = v;
      borrow = 1'b1;
      if (!bcd)
      begin
         r = v - 16'h0001;
      end
      else
      begin
         for (int d = 0; d < 4; d++)
         begin
            if (borrow)
            begin
               if (v[d*4 +: 4] == 4'h0)
               begin
                  r[d*4 +: 4] = 4'h9;
               end
               else
               begin
                  r[d*4 +: 4] = v[d*4 +: 4] - 4'h1;
                  borrow = 1'b0;
               end
            end
         end
      end
      return r;
   endfunction

   // Decrement by a step of one to three
   function automatic logic [15:0] dec_by(input logic [15:0] v,
                                          input logic        bcd,
                                          input logic [1:0]  step);
      logic [15:0] r;
      r = v;
      for (int k = 0; k < 3; k++)
      begin
         if (k < int'(step))
         begin
            r = dec1(r, bcd);
         end
      end
      return r;
   endfunction

   // Behaviour of one counter on a falling edge of its count clock
   function automatic tic_pkg::tic_ctr_t tick(input tic_pkg::tic_ctr_t c_in,
                                              input logic            g);
      tic_pkg::tic_ctr_t c;
      logic [1:0]        step;
      c = c_in;
      step = 2'h2;
      case (c.mode)
         3'h0:
         begin
            if (c.load_pend)
            begin
               c.count = c.init;
               c.load_pend = 1'b0;
               c.null_cnt = 1'b0;
            end
            else if (g && c.armed)
            begin
               if (c.count == 16'h0001)
               begin
                  c.out = 1'b1;
               end
               c.count = dec1(c.count, c.bcd);
            end
         end
         3'h1, 3'h5:
         begin
            if (c.mode == 3'h5)
            begin
               c.out = 1'b1;
            end
            if (c.trig && c.loaded)
            begin
               // Init is only sampled here, so mid-pulse writes wait
               c.count = c.init;
               c.null_cnt = 1'b0;
               c.armed = 1'b1;
               if (c.mode == 3'h1)
               begin
                  c.out = 1'b0;
               end
            end
            else
            begin
               if (c.armed && c.count == 16'h0001)
               begin
                  c.out = (c.mode == 3'h1);
                  c.armed = 1'b0;
               end
               c.count = dec1(c.count, c.bcd);
            end
         end
         3'h2, 3'h3:
         begin
            if (!g)
            begin
               c.out = 1'b1;
            end
            else if (c.load_pend || (c.trig && c.loaded))
            begin
               c.count = c.init;
               c.out = 1'b1;
               c.load_pend = 1'b0;
               c.null_cnt = 1'b0;
            end
            else if (c.loaded && c.mode == 3'h2)
            begin
               if (c.count == 16'h0001)
               begin
                  // Reload at period end picks up any rewritten count
                  c.count = c.init;
                  c.out = 1'b1;
                  c.null_cnt = 1'b0;
               end
               else
               begin
                  c.out = (c.count != 16'h0002);
                  c.count = dec1(c.count, c.bcd);
               end
            end
            else if (c.loaded)
            begin
               if (c.count[0])
               begin
                  step = c.out ? 2'h1 : 2'h3;
               end
               if (c.count == {14'h0000, step})
               begin
                  c.out = ~c.out;
                  c.count = c.init;
                  c.null_cnt = 1'b0;
               end
               else
               begin
                  c.count = dec_by(c.count, c.bcd, step);
               end
            end
         end
         3'h4:
         begin
            c.out = 1'b1;
            if (c.load_pend)
            begin
               c.count = c.init;
               c.load_pend = 1'b0;
               c.null_cnt = 1'b0;
               c.armed = 1'b1;
            end
            else if (g)
            begin
               if (c.armed && c.count == 16'h0001)
               begin
                  c.out = 1'b0;
                  c.armed = 1'b0;
               end
               c.count = dec1(c.count, c.bcd);
            end
         end
         default:
         begin
            c.trig = 1'b0;
         end
      endcase
      c.trig = 1'b0;
      return c;
   endfunction

   // Effect of a completed count write
   function automatic tic_pkg::tic_ctr_t count_done(
      input tic_pkg::tic_ctr_t c_in);
      tic_pkg::tic_ctr_t c;
      c = c_in;
      c.null_cnt = 1'b1;
      case (c.mode)
         3'h0, 3'h4:
         begin
            c.load_pend = 1'b1;
            c.armed = 1'b1;
            if (c.mode == 3'h0)
            begin
               c.out = 1'b0;
            end
         end
         3'h2, 3'h3:
         begin
            c.load_pend = !c.loaded;
         end
         default:
         begin
            c.load_pend = 1'b0;
         end
      endcase
      c.loaded = 1'b1;
      return c;
   endfunction

   tic_pkg::tic_ctr_t [NUM_CTR-1:0] ctr_reg;
   tic_pkg::tic_ctr_t [NUM_CTR-1:0] ctr_next;
   logic [7:0]         rdata_reg;
   logic [7:0]         rdata_next;
   logic [NUM_CTR-1:0] clk_s1_reg;
   logic [NUM_CTR-1:0] clk_s2_reg;
   logic [NUM_CTR-1:0] clk_prev_reg;
   logic [NUM_CTR-1:0] gate_s1_reg;
   logic [NUM_CTR-1:0] gate_s2_reg;
   logic [NUM_CTR-1:0] gate_prev_reg;

   // Pin synchronisers; edges are seen only after the second flop
   always_ff @(posedge ref_clk)
   begin
      if (!reset_n)
      begin
         clk_s1_reg    <= '0;
         clk_s2_reg    <= '0;
         clk_prev_reg  <= '0;
         gate_s1_reg   <= '0;
         gate_s2_reg   <= '0;
         gate_prev_reg <= '0;
      end
      else
      begin
         clk_s1_reg    <= count_clk;
         clk_s2_reg    <= clk_s1_reg;
         clk_prev_reg  <= clk_s2_reg;
         gate_s1_reg   <= count_gate;
         gate_s2_reg   <= gate_s1_reg;
         gate_prev_reg <= gate_s2_reg;
      end
   end

   // Counter channels and host port, next values
   always_comb
   begin
      tic_pkg::tic_ctr_t c;
      logic [15:0]       v;
      logic [1:0]        sel;
      c = '0;
      v = '0;
      sel = host_req.wdata[`TIC_SEL_HI:`TIC_SEL_LO];
      ctr_next = ctr_reg;
      rdata_next = rdata_reg;
      if (host_req.rd)
      begin
         rdata_next = `TIC_UNMAPPED_RD;
      end
      for (int i = 0; i < NUM_CTR; i++)
      begin
         c = ctr_reg[i];
         if (gate_s2_reg[i] && !gate_prev_reg[i])
         begin
            c.trig = 1'b1;
         end
         if (clk_prev_reg[i] && !clk_s2_reg[i])
         begin
            c = tick(c, gate_s2_reg[i]);
         end
         if (c.mode[1] && !gate_s2_reg[i])
         begin
            c.out = 1'b1;
         end
         // Control byte for this counter
         if (host_req.wr && host_req.addr == `TIC_OFS_CTRL)
         begin
            if (sel == `TIC_SEL_READBACK)
            begin
               if (host_req.wdata[`TIC_RB_PICK_LO + i])
               begin
                  if (!host_req.wdata[`TIC_RB_COUNT_N] && !c.cnt_latched)
                  begin
                     c.hold = c.count;
                     c.cnt_latched = 1'b1;
                  end
                  if (!host_req.wdata[`TIC_RB_STATUS_N] && !c.sta_latched)
                  begin
                     c.status = {c.out, c.null_cnt, c.access,
                                 c.mode, c.bcd};
                     c.sta_latched = 1'b1;
                  end
               end
            end
            else if (sel == 2'(i))
            begin
               if (host_req.wdata[`TIC_ACC_HI:`TIC_ACC_LO] == `TIC_ACC_LATCH)
               begin
                  if (!c.cnt_latched)
                  begin
                     c.hold = c.count;
                     c.cnt_latched = 1'b1;
                  end
               end
               else
               begin
                  c = '0;
                  c.access = host_req.wdata[`TIC_ACC_HI:`TIC_ACC_LO];
                  c.mode = host_req.wdata[`TIC_MODE_HI:`TIC_MODE_LO];
                  if (c.mode[1])
                  begin
                     c.mode[2] = 1'b0; // Top bit is don't-care here
                  end
                  c.bcd = host_req.wdata[`TIC_BCD_BIT];
                  c.out = (c.mode != 3'h0);
                  c.null_cnt = 1'b1;
               end
            end
         end
         // Count bytes written to the data port
         if (host_req.wr && host_req.addr == `TIC_OFS_CTR0 + 8'(i))
         begin
            case (c.access)
               `TIC_ACC_LSB:
               begin
                  c.init = {8'h00, host_req.wdata};
                  c = count_done(c);
               end
               `TIC_ACC_MSB:
               begin
                  c.init = {host_req.wdata, 8'h00};
                  c = count_done(c);
               end
               `TIC_ACC_BOTH:
               begin
                  if (!c.wr_hi)
                  begin
                     c.init[7:0] = host_req.wdata;
                     c.wr_hi = 1'b1;
                     if (c.mode == 3'h0)
                     begin
                        c.armed = 1'b0;
                        c.load_pend = 1'b0;
                     end
                  end
                  else
                  begin
                     c.init[15:8] = host_req.wdata;
                     c.wr_hi = 1'b0;
                     c = count_done(c);
                  end
               end
               default:
               begin
                  c.wr_hi = 1'b0;
               end
            endcase
         end
         // Reads: status first, then held or live count
         if (host_req.rd && host_req.addr == `TIC_OFS_CTR0 + 8'(i))
         begin
            v = c.cnt_latched ? c.hold : c.count;
            if (c.sta_latched)
            begin
               rdata_next = c.status;
               c.sta_latched = 1'b0;
            end
            else if (c.access == `TIC_ACC_MSB)
            begin
               rdata_next = v[15:8];
               c.cnt_latched = 1'b0;
            end
            else if (c.access == `TIC_ACC_BOTH && c.rd_hi)
            begin
               rdata_next = v[15:8];
               c.rd_hi = 1'b0;
               c.cnt_latched = 1'b0;
            end
            else
            begin
               rdata_next = v[7:0];
               c.rd_hi = (c.access == `TIC_ACC_BOTH);
               c.cnt_latched = c.cnt_latched && c.rd_hi;
            end
         end
         ctr_next[i] = c;
      end
   end

   // Counter channels and host port, registers
   always_ff @(posedge ref_clk)
   begin
      if (!reset_n)
      begin
         ctr_reg   <= '0;
         rdata_reg <= `TIC_RDATA_RST;
      end
      else
      begin
         ctr_reg   <= ctr_next;
         rdata_reg <= rdata_next;
      end
   end

   // Outputs straight from flops
   always_comb
   begin
      host_rdata = rdata_reg;
      for (int i = 0; i < NUM_CTR; i++)
      begin
         count_out[i] = ctr_reg[i].out;
      end
   end

endmodule

/* File: tic_interval_counter_props.sv */
// Checker for the host port and the output pins of the counter block
`timescale 1ns/1ps
module tic_interval_counter_props
#(
   parameter int NUM_CTR = 3
)
(
   input wire logic               ref_clk,
   input wire logic               reset_n,
   input wire tic_pkg::tic_req_t  host_req,
   input wire logic [7:0]         host_rdata,
   input wire logic [NUM_CTR-1:0] count_clk,
   input wire logic [NUM_CTR-1:0] count_gate,
   input wire logic [NUM_CTR-1:0] count_out
);
   logic [2:0] mode0_reg;
   logic [2:0] mode0_next;
   logic [3:0] glow_reg;
   logic [3:0] glow_next;
   logic       ctl_set;
   logic [1:0] csel;
   logic [2:0] cmode;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);

   // Decode of a mode-setting control byte
   assign ctl_set = host_req.wr && host_req.addr == 8'h1b
                    && host_req.wdata[5:4] != 2'h0;
   assign csel  = host_req.wdata[7:6];
   assign cmode = host_req.wdata[3:1];

   // Counter 0 mode shadow; latch-only bytes leave the mode alone
   always_comb
   begin
      mode0_next = mode0_reg;
      glow_next  = count_gate[0] ? 4'h0 : glow_reg + {3'h0, glow_reg != 4'hf};
      if (ctl_set && csel == 2'h0)
         mode0_next = cmode;
   end

   always_ff @(posedge ref_clk)
   begin
      if (!reset_n)
      begin
         mode0_reg <= 3'h0;
         glow_reg  <= 4'h0;
      end
      else
      begin
         mode0_reg <= mode0_next;
         glow_reg  <= glow_next;
      end
   end

   a_reset_values: assert property (
      $rose(reset_n) |-> host_rdata == 8'h00 && count_out == '0)
      else $error("outputs not at reset values");
   a_rdata_holds: assert property (
      !host_req.rd |=> $stable(host_rdata))
      else $error("read data moved without a read");
   a_ctrl_reads_zero: assert property (
      host_req.rd && host_req.addr == 8'h1b |=> host_rdata == 8'h00)
      else $error("control port read not zero");
   a_unmapped_zero: assert property (
      host_req.rd && (host_req.addr < 8'h18 || host_req.addr > 8'h1b)
      |=> host_rdata == 8'h00)
      else $error("unmapped read not zero");
   a_mode0_low: assert property (
      ctl_set && csel == 2'h2 && cmode == 3'h0 |-> ##[1:4] !count_out[2])
      else $error("stop mode output not low after setup");
   a_mode4_high: assert property (
      ctl_set && csel == 2'h2 && cmode == 3'h4 |-> ##[1:4] count_out[2])
      else $error("strobe mode output not high after setup");
   a_mode2_high: assert property (
      ctl_set && csel == 2'h0 && cmode[1:0] == 2'h2 |-> ##[1:4] count_out[0])
      else $error("rate mode output not high after setup");
   a_gate_forces: assert property (
      mode0_reg[1] && glow_reg >= 4'h6 |-> count_out[0])
      else $error("low gate did not force output high");
   a_pulse_short: assert property (
      $fell(count_out[0]) && mode0_reg[1:0] == 2'h2 |-> ##[1:16] count_out[0])
      else $error("rate pulse longer than one count clock");

   // Main scenarios reached
   c_readback: cover property (ctl_set && csel == 2'h3);
   c_rate_pulse: cover property ($fell(count_out[0]) && mode0_reg == 3'h2);
   c_gate_held: cover property (glow_reg == 4'hf && mode0_reg[1]);
endmodule

bind tic_interval_counter
   tic_interval_counter_props #(.NUM_CTR(NUM_CTR)) u_props (
      .ref_clk    (ref_clk),
      .reset_n    (reset_n),
      .host_req   (host_req),
      .host_rdata (host_rdata),
      .count_clk  (count_clk),
      .count_gate (count_gate),
      .count_out  (count_out)
   );

/* File: tic_pin_model.sv */
// Free-running count clock source and gate drivers for the counters
`timescale 1ns/1ps
module tic_pin_model
#(
   parameter int HALF = 6
)
(
   input  wire logic       ref_clk,
   input  wire logic       reset_n,
   input  wire logic [2:0] gate_set,
   output logic [2:0]      count_clk,
   output logic [2:0]      count_gate
);
   logic [3:0] tick_reg;
   logic [3:0] tick_next;
   logic [2:0] clk_reg;
   logic [2:0] clk_next;

   // Each level lasts HALF cycles, well above the two-cycle minimum
   always_comb
   begin
      tick_next = tick_reg + 4'h1;
      clk_next  = clk_reg;
      if (tick_reg == 4'(HALF - 1))
      begin
         tick_next = 4'h0;
         clk_next  = ~clk_reg;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (!reset_n)
      begin
         tick_reg <= 4'h0;
         clk_reg  <= 3'h7;
      end
      else
      begin
         tick_reg <= tick_next;
         clk_reg  <= clk_next;
      end
   end

   // One clock and one gate per counter
   assign count_clk  = clk_reg;
   assign count_gate = gate_set;
endmodule

/* File: test_triple_interval_counter.sv */
// Self-checking testbench of the triple interval counter
`timescale 1ns/1ps
module test_triple_interval_counter;
   logic              ref_clk    = 1'b0;
   logic              reset_n    = 1'b0;
   tic_pkg::tic_req_t host_req   = '0;
   logic [2:0]        gate_set   = 3'h7;
   logic [7:0]        host_rdata;
   logic [2:0]        count_clk;
   logic [2:0]        count_gate;
   logic [2:0]        count_out;
   logic [7:0]        lows;
   logic [7:0]        run;
   logic [7:0]        lsb_a;
   logic [7:0]        lsb_b;
   logic [7:0]        msb;
   int                num_errors = 0;
   int                n_tests    = 0;
   int                cyc        = 0;

   always #20 ref_clk = ~ref_clk;

   tic_interval_counter dut (
      .ref_clk    (ref_clk),
      .reset_n    (reset_n),
      .host_req   (host_req),
      .host_rdata (host_rdata),
      .count_clk  (count_clk),
      .count_gate (count_gate),
      .count_out  (count_out)
   );

   tic_pin_model u_pins (
      .ref_clk    (ref_clk),
      .reset_n    (reset_n),
      .gate_set   (gate_set),
      .count_clk  (count_clk),
      .count_gate (count_gate)
   );

   task wrap_up;
      $display("checks %0d errors %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // Whole run needs under two thousand cycles; the ceiling leaves wide margin
   always @(posedge ref_clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         num_errors++;
         wrap_up();
      end
   end

   task check(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // One-cycle write strobe, released a cycle before the next access
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      #1;
      host_req.wr    = 1'b1;
      host_req.addr  = a;
      host_req.wdata = d;
      @(posedge ref_clk);
      #1;
      host_req.wr = 1'b0;
   endtask

   task rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge ref_clk);
      #1;
      host_req.rd   = 1'b1;
      host_req.addr = a;
      @(posedge ref_clk);
      #1;
      host_req.rd = 1'b0;
      @(posedge ref_clk);
      #1;
      d = host_rdata;
   endtask

   // Low byte then high byte, as access kind 11 pairs them
   task load(input logic [7:0] a, input logic [15:0] v);
      wr(a, v[7:0]);
      wr(a, v[15:8]);
   endtask

   // Samples an output mid count-clock, counting lows and longest low run
   task watch(input int ch, input int warm, input int n);
      logic [7:0] cur;
      lows = 8'h00;
      run  = 8'h00;
      cur  = 8'h00;
      repeat (warm) @(posedge count_clk[0]);
      repeat (n)
      begin
         @(posedge count_clk[0]);
         #1;
         if (count_out[ch] === 1'b0)
         begin
            lows++;
            cur++;
            if (cur > run)
               run = cur;
         end
         else
            cur = 8'h00;
      end
   endtask

   initial
   begin
      repeat (12) @(posedge ref_clk);
      #1;
      reset_n = 1'b1;
      // Rate generator on counter 0, then gate held low and released
      wr(8'h1b, 8'h34);
      load(8'h18, 16'h0004);
      check(count_out[0], 1'b1);
      watch(0, 2, 12);
      check(lows, 8'h03);
      check(run, 8'h01);
      gate_set[0] = 1'b0;
      watch(0, 1, 8);
      check(lows, 8'h00);
      gate_set[0] = 1'b1;
      watch(0, 2, 12);
      check(lows, 8'h03);
      // Odd square wave on counter 1: three high, two low
      wr(8'h1b, 8'h76);
      load(8'h19, 16'h0005);
      watch(1, 3, 10);
      check(lows, 8'h04);
      check(run, 8'h02);
      // Stop on terminal count on counter 2, then both latch kinds
      wr(8'h1b, 8'hb0);
      check(count_out[2], 1'b0);
      load(8'h1a, 16'h0003);
      watch(2, 0, 8);
      check(count_out[2], 1'b1);
      wr(8'h1b, 8'h80);
      rd(8'h1a, lsb_a);
      rd(8'h1a, msb);
      check(msb, 8'hff);
      // Two reads are shorter than a count clock; let one tick pass
      watch(2, 0, 2);
      wr(8'h1b, 8'hd8);
      rd(8'h1a, lsb_b);
      rd(8'h1a, msb);
      check(msb, 8'hff);
      check(lsb_a !== lsb_b, 1'b1);
      wr(8'h1b, 8'he8);
      rd(8'h1a, msb);
      check(msb, 8'hb0);
      // Decimal count on counter 2 wraps from zero to 9999
      wr(8'h1b, 8'hb1);
      load(8'h1a, 16'h0003);
      watch(2, 0, 8);
      wr(8'h1b, 8'h80);
      rd(8'h1a, lsb_a);
      rd(8'h1a, msb);
      check(msb, 8'h99);
      check(lsb_a[7:4], 4'h9);
      // Software strobe on counter 2, with the gate suspending it
      wr(8'h1b, 8'hb8);
      load(8'h1a, 16'h0003);
      check(count_out[2], 1'b1);
      watch(2, 0, 10);
      check(lows, 8'h01);
      check(run, 8'h01);
      gate_set[2] = 1'b0;
      load(8'h1a, 16'h0003);
      watch(2, 0, 8);
      check(lows, 8'h00);
      gate_set[2] = 1'b1;
      watch(2, 0, 10);
      check(lows, 8'h01);
      // One-shot on counter 1: rests high until a gate rise
      gate_set[1] = 1'b0;
      wr(8'h1b, 8'h72);
      load(8'h19, 16'h0003);
      watch(1, 0, 4);
      check(lows, 8'h00);
      gate_set[1] = 1'b1;
      watch(1, 0, 8);
      check(lows, 8'h03);
      check(run, 8'h03);
      // Hardware strobe on counter 0 needs a fresh gate rise
      wr(8'h1b, 8'h3a);
      load(8'h18, 16'h0003);
      watch(0, 0, 6);
      check(lows, 8'h00);
      gate_set[0] = 1'b0;
      watch(0, 0, 1);
      gate_set[0] = 1'b1;
      watch(0, 0, 10);
      check(lows, 8'h01);
      check(run, 8'h01);
      // Write-only control port and a hole in the map read as zero
      rd(8'h1b, msb);
      check(msb, 8'h00);
      rd(8'h20, msb);
      check(msb, 8'h00);
      wrap_up();
   end
endmodule
